// *** core/chsp_pkg.sv ***
// Package for the card host strobe port: modes, timing counts and carriers.
// Assumes a single 25 MHz clock drives every module that imports it.
package chsp_pkg;
	// ==========================================================
	// Clock and strobe timing
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SETUP_NS        = 70;
	localparam int STROBE_NS       = 165;
	localparam int HOLD_NS         = 30;
	localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 4;
	localparam int ADDR_W          = 11;
	localparam int DATA_W          = 16;
	localparam int FIFO_DEPTH      = 8;
	localparam int TASK_ADDR_W     = 3;
	localparam logic [7:0] BYTE_MASK = 8'hFF;

	// ==========================================================
	// Operating modes, the access kinds and the strobe sequencer states
	typedef enum logic [1:0] {
		CHSP_MODE_MEM = 2'h0,
		CHSP_MODE_IO  = 2'h1,
		CHSP_MODE_IDE = 2'h3
	} chsp_mode_type;

	typedef enum logic [1:0] {
		CHSP_ACC_DATA = 2'h0,
		CHSP_ACC_TASK = 2'h1,
		CHSP_ACC_CFG  = 2'h2
	} chsp_kind_type;

	typedef enum logic [1:0] {
		CHSP_ST_IDLE   = 2'h0,
		CHSP_ST_SETUP  = 2'h1,
		CHSP_ST_STROBE = 2'h3,
		CHSP_ST_HOLD   = 2'h2
	} chsp_state_type;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic                  write;
		chsp_kind_type         kind;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} chsp_req_type;

	typedef struct packed {
		logic                  insert_detect_a_n;
		logic                  insert_detect_b_n;
		logic                  battery_status_two;
		logic                  audio_out_n;
	} chsp_stat_type;
endpackage

// *** core/chsp_fifo.sv ***
// Synchronous request FIFO for the card host strobe port.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module chsp_fifo
	import chsp_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rstn_i,
	// Filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	// ==========================================================
	// Elaboration check: the pointers wrap by themselves only for powers of two.
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
			$error("chsp_fifo depth must be a power of two of at least two");
		end
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_o  = (count_r != (PW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage is written only; no reset needed on the data itself.
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// Pointers and count.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	a_fifo_no_overflow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		count_r <= (PW+1)'(DEPTH))
		else $error("FIFO count exceeds depth");
endmodule

// *** core/chsp_host.sv ***
// Host controller for a removable flash card's parallel strobe port.
// Assumes card pins are synchronous to mclk_i and that the bench resolves the
// two-way pins from their enables (enable low means this side drives).
`timescale 1ns/1ps

module chsp_host
	import chsp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                mclk_i,
	input  wire logic                rstn_i,
	// Mode selection, held stable while out of reset
	input  wire chsp_mode_type       mode_i,
	// Request port
	input  wire logic                req_valid_i,
	output logic                     req_ready_o,
	input  wire chsp_req_type        req_i,
	// Read answer
	output logic                     rsp_valid_o,
	output logic [DATA_W-1:0]        rsp_data_o,
	// Card status as seen by the host
	output logic                     card_present_o,
	output chsp_stat_type            card_stat_o,
	output logic                     peer_active_o,
	input  wire logic                peer_assert_i,
	// Card pins: address, strobes and mode select
	output logic [ADDR_W-1:0]        addr_o,
	output logic                     output_enable_n_o,
	output logic                     mem_write_strobe_n_o,
	output logic                     io_read_strobe_n_o,
	output logic                     io_write_strobe_n_o,
	// Card pins: data bus
	input  wire logic [DATA_W-1:0]   data_i,
	output logic [DATA_W-1:0]        data_o,
	output logic                     data_oe_n_o,
	// Card pins: status lines
	input  wire logic                insert_detect_a_n_i,
	input  wire logic                insert_detect_b_n_i,
	input  wire logic                battery_status_two_i,
	input  wire logic                audio_out_n_i,
	input  wire logic                drive_active_present_n_i,
	output logic                     drive_active_present_n_o,
	output logic                     drive_active_present_oe_n_o
);
	localparam int RW = $bits(chsp_req_type);

	// ==========================================================
	// Elaboration check on parameters.
	initial begin
		if (SETUP_CYC < 1 || STROBE_CYC < 1 || HOLD_CYC < 1 ||
		    STROBE_CYC >= (1 << CNT_W)) begin
			$error("chsp_host strobe timing does not fit the counter");
		end
	end

	// Keeps a task-file value on the low lanes with the upper byte cleared.
	function automatic logic [DATA_W-1:0] low_lane(input logic [DATA_W-1:0] v);
		low_lane = {8'h00, v[7:0] & BYTE_MASK};
	endfunction

	// ==========================================================
	// Request buffer: the sequencer drains it, so back-pressure reaches the user.
	logic         q_valid;
	logic         q_ready;
	logic [RW-1:0] q_data;
	chsp_req_type cur;

	chsp_fifo #(
		.WIDTH (RW),
		.DEPTH (DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (req_valid_i),
		.in_ready_o  (req_ready_o),
		.in_data_i   (req_i),
		.out_valid_o (q_valid),
		.out_ready_i (q_ready),
		.out_data_o  (q_data)
	);

	// ==========================================================
	// Mode latch: taken once, a cycle after reset release.
	chsp_mode_type mode_r;
	chsp_mode_type mode_eff;
	logic          mode_taken_r;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r       <= CHSP_MODE_MEM;
			mode_taken_r <= 1'b0;
		end else if (!mode_taken_r) begin
			mode_r       <= mode_i;
			mode_taken_r <= 1'b1;
		end
	end

	// ==========================================================
	// Strobe sequencer.
	chsp_state_type state_r;
	logic [CNT_W-1:0] cnt_r;
	chsp_req_type     act_r;
	logic             io_path;
	logic             start;
	logic             phase_done;

	assign cur        = chsp_req_type'(q_data);
	assign start      = (state_r == CHSP_ST_IDLE) && q_valid && mode_taken_r;
	assign q_ready    = start;
	assign phase_done = (cnt_r == '0);

	// I/O strobes never used in memory mode
	// Write strobe only for configuration in I/O mode
	// IDE uses the I/O strobes as well
	assign io_path = (mode_r != CHSP_MODE_MEM) && (act_r.kind != CHSP_ACC_CFG);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= CHSP_ST_IDLE;
			cnt_r   <= '0;
			act_r   <= '0;
		end else begin
			case (state_r)
				CHSP_ST_IDLE: begin
					if (start) begin
						act_r   <= cur;
						cnt_r   <= CNT_W'(SETUP_CYC - 1);
						state_r <= CHSP_ST_SETUP;
					end
				end
				CHSP_ST_SETUP: begin
					if (phase_done) begin
						cnt_r   <= CNT_W'(STROBE_CYC - 1);
						state_r <= CHSP_ST_STROBE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				CHSP_ST_STROBE: begin
					if (phase_done) begin
						cnt_r   <= CNT_W'(HOLD_CYC - 1);
						state_r <= CHSP_ST_HOLD;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				CHSP_ST_HOLD: begin
					if (phase_done) begin
						state_r <= CHSP_ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					state_r <= CHSP_ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Pin drive. I/O and write strobes are registered so they never glitch on the cable; output enable is combinational.
	logic strobing;
	logic busy;

	assign strobing = (state_r == CHSP_ST_STROBE);
	assign busy     = (state_r != CHSP_ST_IDLE);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_o               <= '0;
			data_o               <= '0;
			data_oe_n_o          <= 1'b1;
			io_read_strobe_n_o   <= 1'b1;
			io_write_strobe_n_o  <= 1'b1;
			mem_write_strobe_n_o <= 1'b1;
		end else begin
			// Only A2:A0 carry meaning in IDE mode
			if (mode_r == CHSP_MODE_IDE) begin
				addr_o <= {{(ADDR_W-TASK_ADDR_W){1'b0}}, act_r.addr[TASK_ADDR_W-1:0]};
			end else begin
				addr_o <= act_r.addr;
			end
			// Task-file writes on the low byte
			if (mode_r == CHSP_MODE_IDE && act_r.kind == CHSP_ACC_TASK) begin
				data_o <= low_lane(act_r.wdata);
			end else begin
				data_o <= act_r.wdata;
			end
			// Data driven from setup through hold, so it is stable at the rising edge.
			data_oe_n_o <= !(busy && act_r.write);
			// Read strobe low only during the strobe phase
			io_read_strobe_n_o <= !(strobing && !act_r.write && io_path);
			// Rising edge ends the write pulse before hold
			io_write_strobe_n_o <= !(strobing && act_r.write && io_path);
			// Write strobe held high in IDE mode
			mem_write_strobe_n_o <= !(strobing && act_r.write && !io_path &&
			                          mode_r != CHSP_MODE_IDE);
		end
	end

	// Output enable held low for IDE mode
	// Otherwise pulsed low for memory-space reads
	// Until the latch closes the mode input decides, so the card sees IDE during reset.
	assign mode_eff          = mode_taken_r ? mode_r : mode_i;
	assign output_enable_n_o = (mode_eff == CHSP_MODE_IDE) ? 1'b0 :
	                           !(io_read_strobe_n_o && mem_write_strobe_n_o &&
	                             strobing && !act_r.write && !io_path);

	// ==========================================================
	// Read capture at the end of the strobe phase.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= '0;
		end else begin
			rsp_valid_o <= 1'b0;
			if (strobing && phase_done && !act_r.write) begin
				rsp_valid_o <= 1'b1;
				if (mode_r == CHSP_MODE_IDE && act_r.kind == CHSP_ACC_TASK) begin
					rsp_data_o <= low_lane(data_i);
				end else begin
					rsp_data_o <= data_i;
				end
			end
		end
	end

	// ==========================================================
	// Card status.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			card_present_o <= 1'b0;
			card_stat_o    <= '0;
			peer_active_o  <= 1'b0;
		end else begin
			// Both detects low means fully seated
			card_present_o <= (mode_r == CHSP_MODE_IDE) ? 1'b1 :
			                  (!insert_detect_a_n_i && !insert_detect_b_n_i);
			card_stat_o <= '{insert_detect_a_n_i, insert_detect_b_n_i,
			                 battery_status_two_i, audio_out_n_i};
			// Sense the shared line in IDE mode
			peer_active_o <= (mode_r == CHSP_MODE_IDE) && !drive_active_present_n_i;
		end
	end

	// Host pulls the line low only in IDE mode; open drain style.
	assign drive_active_present_n_o    = 1'b0;
	assign drive_active_present_oe_n_o = !(mode_r == CHSP_MODE_IDE && peer_assert_i);

	// ==========================================================
	// Checks.
	a_no_io_in_mem: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_r == CHSP_MODE_MEM |-> io_read_strobe_n_o && io_write_strobe_n_o)
		else $error("I/O strobe pulsed in memory mode");
	a_ide_we_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_r == CHSP_MODE_IDE |-> mem_write_strobe_n_o)
		else $error("Write strobe low in IDE mode");
	a_ide_oe_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_r == CHSP_MODE_IDE |-> !output_enable_n_o)
		else $error("Output enable high in IDE mode");
	a_wr_data_held: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(io_write_strobe_n_o) |-> !data_oe_n_o && $stable(data_o))
		else $error("Write data not held at strobe rising edge");
	a_rd_no_drive: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!io_read_strobe_n_o |-> data_oe_n_o)
		else $error("Host drives bus during read strobe");
	a_ide_addr_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_r == CHSP_MODE_IDE |=> addr_o[ADDR_W-1:TASK_ADDR_W] == '0)
		else $error("High address lines set in IDE mode");
	a_task_low_byte: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(mode_r == CHSP_MODE_IDE && act_r.kind == CHSP_ACC_TASK && !data_oe_n_o)
		|-> data_o[15:8] == 8'h00)
		else $error("Task-file write uses the upper byte");
	a_mode_stable: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_taken_r |=> $stable(mode_r))
		else $error("Mode changed after capture");
	a_present_seen: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(mode_r != CHSP_MODE_IDE && insert_detect_a_n_i) |=> !card_present_o)
		else $error("Card present with a detect line high");
	a_strobe_width: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$fell(io_read_strobe_n_o) |-> !io_read_strobe_n_o [*5] ##1 io_read_strobe_n_o)
		else $error("Read strobe width wrong");

	c_io_write: cover property (@(posedge mclk_i) $rose(io_write_strobe_n_o));
	c_io_read: cover property (@(posedge mclk_i) rsp_valid_o && mode_r == CHSP_MODE_IDE);
	c_mem_write: cover property (@(posedge mclk_i) $rose(mem_write_strobe_n_o));
	c_fifo_full: cover property (@(posedge mclk_i) req_valid_i && !req_ready_o);
endmodule

// *** testbench/chsp_card_model.sv ***
// Behavioural model of the removable flash card on the far side of the host.
// Assumes the bench tells it the mode and whether the card is seated.
`timescale 1ns/1ps
module chsp_card_model
	import chsp_pkg::*;
(
	// Clock, reset and set-up from the bench
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire chsp_mode_type     mode_i,
	input  wire logic              seated_i,
	input  wire logic              peer_pull_i,
	// Strobes and address from the host
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              oe_n_i,
	input  wire logic              we_n_i,
	input  wire logic              io_read_strobe_n_i,
	input  wire logic              io_write_strobe_n_i,
	// Host side of the shared lines
	input  wire logic [DATA_W-1:0] host_data_i,
	input  wire logic              host_oe_n_i,
	input  wire logic              host_active_n_i,
	input  wire logic              host_active_oe_n_i,
	// Resolved lines
	output logic [DATA_W-1:0]      bus_o,
	output chsp_stat_type          stat_o,
	output logic                   drive_active_present_n_o
);
	// ==========================================================
	// Storage
	logic [DATA_W-1:0] io_mem [8];
	logic [DATA_W-1:0] mm_mem [8];
	logic [DATA_W-1:0] last_r = '0;
	logic [DATA_W-1:0] card_q;
	logic              card_drv;
	logic              ide = 1'b0;

	// Mode fixed at reset
	// The card reads IDE mode from the output-enable level while reset holds, then keeps it.
	always @(posedge mclk_i) begin
		if (!rstn_i) begin
			ide <= !oe_n_i;
		end
	end

	// read gating
	// The output-enable level is tied low in IDE mode, so it must not open the bus there.
	always_comb begin
		card_drv = 1'b0;
		card_q   = '0;
		if (!io_read_strobe_n_i && mode_i != CHSP_MODE_MEM) begin
			card_drv = 1'b1;
			card_q   = io_mem[addr_i[2:0]];
		end else if (!oe_n_i && !ide) begin
			card_drv = 1'b1;
			card_q   = mm_mem[addr_i[2:0]];
		end
	end

	// bus resolution
	// A released bus shows the inverse of its last value, so stale data never passes.
	always_comb begin
		if (!host_oe_n_i) begin
			bus_o = host_data_i;
		end else if (card_drv) begin
			bus_o = card_q;
		end else begin
			bus_o = ~last_r;
		end
	end

	// Remember the last driven value.
	always @(posedge mclk_i) begin
		if (!host_oe_n_i || card_drv) begin
			last_r <= bus_o;
		end
	end

	always @(posedge io_write_strobe_n_i) begin
		if (mode_i != CHSP_MODE_MEM) begin
			io_mem[addr_i[2:0]] = bus_o;
		end
	end

	always @(posedge we_n_i) begin
		if (!ide) begin
			mm_mem[addr_i[2:0]] = bus_o;
		end
	end

	// status pins
	// One shared pin carries battery, audio and drive-active; it has a pull-up.
	// The host's driven level counts only while its enable is low.
	assign drive_active_present_n_o = ide ?
	                                  !(peer_pull_i || (!host_active_oe_n_i && !host_active_n_i)) :
	                                  1'b1;
	assign stat_o.insert_detect_a_n  = ide ? 1'b1 : !seated_i;
	assign stat_o.insert_detect_b_n  = ide ? 1'b1 : !seated_i;
	assign stat_o.battery_status_two = drive_active_present_n_o;
	assign stat_o.audio_out_n        = drive_active_present_n_o;
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the card host strobe port against the card model.
// Assumes the package constants and one 25 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench
	import chsp_pkg::*;
;
	// ==========================================================
	// Signals
	logic              mclk_i = 1'b0;
	logic              rstn_i = 1'b0;
	chsp_mode_type     mode_i = CHSP_MODE_MEM;
	logic              req_valid_i = 1'b0;
	chsp_req_type      req_i = '0;
	logic              peer_assert_i = 1'b0;
	logic              seated = 1'b1;
	logic              peer_pull = 1'b0;
	logic              req_ready_o, rsp_valid_o, card_present_o, peer_active_o;
	logic [DATA_W-1:0] rsp_data_o, data_o, bus, q;
	logic [ADDR_W-1:0] addr_o;
	logic              oe_n, we_n, io_rd_n, io_wr_n, data_oe_n, active_n, active_d, active_oe_n;
	chsp_stat_type     card_stat_o, pins;
	int                n_mismatch = 0;
	int                checked = 0;
	int                n_io = 0;
	int                n_we = 0;

	// Clock and strobe counters.
	always #20 mclk_i = ~mclk_i;
	always @(negedge io_rd_n or negedge io_wr_n) n_io++;
	always @(negedge we_n) n_we++;

	chsp_host #(.DEPTH(FIFO_DEPTH)) chsp_host_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(mode_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.card_present_o(card_present_o), .card_stat_o(card_stat_o),
		.peer_active_o(peer_active_o), .peer_assert_i(peer_assert_i),
		.addr_o(addr_o), .output_enable_n_o(oe_n), .mem_write_strobe_n_o(we_n),
		.io_read_strobe_n_o(io_rd_n), .io_write_strobe_n_o(io_wr_n),
		.data_i(bus), .data_o(data_o), .data_oe_n_o(data_oe_n),
		.insert_detect_a_n_i(pins.insert_detect_a_n),
		.insert_detect_b_n_i(pins.insert_detect_b_n),
		.battery_status_two_i(pins.battery_status_two), .audio_out_n_i(pins.audio_out_n),
		.drive_active_present_n_i(active_n), .drive_active_present_n_o(active_d),
		.drive_active_present_oe_n_o(active_oe_n));

	chsp_card_model chsp_card_model_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(mode_i), .seated_i(seated),
		.peer_pull_i(peer_pull), .addr_i(addr_o), .oe_n_i(oe_n), .we_n_i(we_n),
		.io_read_strobe_n_i(io_rd_n), .io_write_strobe_n_i(io_wr_n),
		.host_data_i(data_o), .host_oe_n_i(data_oe_n), .host_active_n_i(active_d),
		.host_active_oe_n_i(active_oe_n), .bus_o(bus), .stat_o(pins),
		.drive_active_present_n_o(active_n));

	// ==========================================================
	// Shared tasks
	task automatic final_report();
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// Valid drops on the taking edge, so a following call always starts one edge later.
	task automatic push(input logic w, input chsp_kind_type k, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_i <= '{write: w, kind: k, addr: a, wdata: d};
		do begin @(posedge mclk_i); n++; end while (req_ready_o !== 1'b1 && n < 300);
		req_valid_i <= 1'b0;
		if (n >= 300) begin n_mismatch++; final_report(); end
	endtask

	task automatic rd(input chsp_kind_type k, input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		push(1'b0, k, a, '0);
		do begin @(negedge mclk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 100);
		if (n >= 100) begin n_mismatch++; final_report(); end
		q = rsp_data_o;
	endtask

	task automatic do_reset(input chsp_mode_type m);
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		mode_i <= m;
		repeat (20) @(posedge mclk_i);
		rstn_i <= 1'b1;
		settle(3);
		n_io = 0;
		n_we = 0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_mem();
		do_reset(CHSP_MODE_MEM);
		`CHK("present", 1'b1, card_present_o)
		`CHK("detects", 2'b00, {card_stat_o.insert_detect_a_n, card_stat_o.insert_detect_b_n})
		`CHK("battery", 1'b1, card_stat_o.battery_status_two)
		push(1'b1, CHSP_ACC_DATA, 11'h002, 16'hA55A);
		push(1'b1, CHSP_ACC_CFG, 11'h005, 16'h0033);
		rd(CHSP_ACC_DATA, 11'h002);
		`CHK("mem word", 16'hA55A, q)
		rd(CHSP_ACC_CFG, 11'h005);
		`CHK("cfg word", 16'h0033, q)
		`CHK("io strobes", 0, n_io)
		`CHK("mem writes", 2, n_we)
		@(posedge mclk_i);
		seated <= 1'b0;
		settle(4);
		`CHK("absent", 1'b0, card_present_o)
		@(posedge mclk_i);
		seated <= 1'b1;
	endtask

	task automatic sc_io();
		do_reset(CHSP_MODE_IO);
		`CHK("audio", 1'b1, card_stat_o.audio_out_n)
		push(1'b1, CHSP_ACC_DATA, 11'h001, 16'h5AA5);
		push(1'b1, CHSP_ACC_CFG, 11'h006, 16'h0044);
		rd(CHSP_ACC_DATA, 11'h001);
		`CHK("io word", 16'h5AA5, q)
		rd(CHSP_ACC_CFG, 11'h006);
		`CHK("cfg word", 16'h0044, q)
		`CHK("cfg strobes", 1, n_we)
		`CHK("io strobes", 2, n_io)
	endtask

	// Sixteen writes outrun the sequencer, so the queue must refuse before it drains.
	task automatic sc_fill();
		logic full;
		full = 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(negedge mclk_i);
			if (req_ready_o === 1'b0) full = 1'b1;
			push(1'b1, CHSP_ACC_DATA, 11'(i % 8), 16'h1000 + 16'(i));
		end
		`CHK("queue refused", 1'b1, full)
		rd(CHSP_ACC_DATA, 11'h003);
		`CHK("queue order", 16'h100B, q)
		rd(CHSP_ACC_DATA, 11'h007);
		`CHK("queue tail", 16'h100F, q)
	endtask

	task automatic sc_ide();
		do_reset(CHSP_MODE_IDE);
		@(posedge mclk_i);
		seated <= 1'b0;
		settle(4);
		`CHK("ide select", 1'b0, oe_n)
		`CHK("ide present", 1'b1, card_present_o)
		push(1'b1, CHSP_ACC_DATA, 11'h000, 16'hBEEF);
		push(1'b1, CHSP_ACC_TASK, 11'h7FD, 16'h1234);
		rd(CHSP_ACC_TASK, 11'h005);
		`CHK("task byte", 16'h0034, q)
		rd(CHSP_ACC_TASK, 11'h000);
		`CHK("task lane", 16'h00EF, q)
		rd(CHSP_ACC_DATA, 11'h000);
		`CHK("ide word", 16'hBEEF, q)
		`CHK("ide mem strobes", 0, n_we)
		@(posedge mclk_i);
		peer_pull <= 1'b1;
		settle(4);
		`CHK("peer seen", 1'b1, peer_active_o)
		@(posedge mclk_i);
		peer_pull <= 1'b0;
		peer_assert_i <= 1'b1;
		settle(4);
		`CHK("line pulled", 1'b0, active_n)
	endtask

	// Main sequence.
	initial begin
		sc_mem();
		sc_io();
		sc_fill();
		sc_ide();
		final_report();
	end
endmodule
